// File: inc/scr_pkg.sv
/*
 * Shared constants and types for the command-response SPI slave.
 * Assumes a compiler that accepts SystemVerilog packages; every user
 * refers to these items as scr_pkg::name.
 */
package scr_pkg;

    // ****************************************************************
    // control word field positions
    // ****************************************************************
    localparam int unsigned CTRL_EASY_MODE_BIT   = 10; // buffer protocol
    localparam int unsigned CTRL_BYTE_MODE_BIT   = 11; // 8-bit elements
    localparam int unsigned CTRL_COMMAND_RESPONSE_BUFFER_MODE_BIT    = 12; // command-response
    localparam int unsigned CTRL_SEL_EXT_CLK_BIT = 13; // select detect
    localparam int unsigned CTRL_OP_EXT_CLK_BIT  = 14; // protocol clock
    localparam logic [31:0] CTRL_RESET_VALUE     = 32'h0000_0000;

    // ****************************************************************
    // frame format and buffer geometry
    // ****************************************************************
    localparam logic [1:0] FMT_STD_SPI    = 2'h0; // only legal format
    localparam int unsigned BUF_DEPTH     = 256;
    localparam int unsigned BUF_ADDR_W    = 8;
    localparam int unsigned BUF_DATA_W    = 8;
    localparam logic [7:0] ADDR_LAST      = 8'hff;
    localparam logic [7:0] ADDR_RESET     = 8'h00;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [2:0] BIT_RESET      = 3'h0;

    // ****************************************************************
    // reply bytes driven during the first byte of a frame
    // ****************************************************************
    localparam logic [7:0] REPLY_CR_READY = 8'h62;
    localparam logic [7:0] REPLY_CR_BUSY  = 8'hff;
    localparam logic [7:0] REPLY_EZ_READY = 8'hfe;
    localparam logic [7:0] REPLY_EZ_BUSY  = 8'hff;
    localparam logic [7:0] REPLY_IDLE     = 8'hff;
    localparam logic [7:0] BYTE_RESET     = 8'hff;

    // ****************************************************************
    // frame state in the system domain
    // ****************************************************************
    typedef enum logic [2:0] {
        SCR_FS_IDLE = 3'b001, // deselected
        SCR_FS_CMD  = 3'b010, // waiting for selection byte
        SCR_FS_DATA = 3'b100  // write or read phase running
    } scr_frame_t;

endpackage : scr_pkg

// File: logic/scr_spi_slave.sv
/*
 * Command-response SPI slave with clock-mode selection: a 256-byte
 * buffer, base/current read and write addresses, first-byte status
 * reply and frame-end events.
 * Assumes an external SPI master (mode 0: sample on rising SCLK,
 * drive on falling) and CPU logic on SYS_CLK_IN that holds a buffer
 * request until it is acknowledged.
 */
// Notes on behaviour
// - easy mode, split clocks: 0xFF until clock
// - 256 bytes, addresses 0 to 255
// - cpu word access, low byte only
// - write phase: load base, store, increment
// - read phase: load base, send, increment
// - current addresses saturate at 255
// - base from cpu, current readable after
// - all power modes, standard frame format
// - selection byte last bit picks phase
// - first byte 0x62 ready, else busy
// - defined only for slave operation
// - off at reset, bit 12 plus bits
// - two bits choose internal/external clocking
// - external clocking uses SCLK, slave only
// - both bits zero: no 0x62 reply
// - external select detect raises wake cause
// - fifo split clocks: 0xFF, mosi dropped
// - easy mode reply 0xFF sleep, 0xFE active
// - both bits one: end causes on deselect
// - external protocol clock serves buffer traffic
module scr_spi_slave #(
    parameter int unsigned DEPTH  = scr_pkg::BUF_DEPTH,
    parameter int unsigned ADDR_W = scr_pkg::BUF_ADDR_W
) (
    // system clock and reset
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RESET_N_IN,
    // spi link
    input  wire logic        SCLK_IN,
    input  wire logic        SSEL_N_IN,
    input  wire logic        MOSI_IN,
    output logic             MISO_OUT,
    output logic             MISO_OE_OUT,
    // configuration
    input  wire logic [31:0] CTRL_IN,
    input  wire logic        ENABLE_IN,
    input  wire logic        SLAVE_MODE_IN,
    input  wire logic [1:0]  FRAME_FMT_IN,
    input  wire logic        BLOCK_CLOCK_GATE_IN,
    input  wire logic [7:0]  BASE_RD_ADDR_IN,
    input  wire logic [7:0]  BASE_WR_ADDR_IN,
    // cpu buffer window
    input  wire logic        CPU_REQ_IN,
    input  wire logic        CPU_WE_IN,
    input  wire logic [7:0]  CPU_ADDR_IN,
    input  wire logic [31:0] CPU_WDATA_IN,
    output logic [31:0]      CPU_RDATA_OUT,
    output logic             CPU_ACK_OUT,
    // status and event causes
    output logic [7:0]       CUR_RD_ADDR_OUT,
    output logic [7:0]       CUR_WR_ADDR_OUT,
    output logic             BUS_BUSY_OUT,
    output logic             COMMAND_RESPONSE_BUFFER_MODE_ACTIVE_OUT,
    output logic             WAKE_UP_OUT,
    output logic             XFER_END_OUT,
    output logic             WRITE_END_OUT
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // saturating increment of a buffer address
    function automatic logic [7:0] sat_inc(input logic [7:0] a);
        sat_inc = (a == scr_pkg::ADDR_LAST) ? a : a + 8'h01;
    endfunction : sat_inc

    // ****************************************************************
    // configuration decode (system domain)
    // ****************************************************************
    logic sel_ext_clk;
    logic op_ext_clk;
    logic command_response_buffer_mode_select;
    logic easy_buffer_mode;
    logic command_response_buffer_mode_ok;
    logic ez_ready;

    // slave-only, standard format, mode bits 11 to 14 set
    always_comb begin
        sel_ext_clk      = CTRL_IN[scr_pkg::CTRL_SEL_EXT_CLK_BIT];
        op_ext_clk       = CTRL_IN[scr_pkg::CTRL_OP_EXT_CLK_BIT];
        command_response_buffer_mode_select  = CTRL_IN[scr_pkg::CTRL_COMMAND_RESPONSE_BUFFER_MODE_BIT];
        easy_buffer_mode = CTRL_IN[scr_pkg::CTRL_EASY_MODE_BIT];
        command_response_buffer_mode_ok      = ENABLE_IN && SLAVE_MODE_IN
                        && (FRAME_FMT_IN == scr_pkg::FMT_STD_SPI)
                        && command_response_buffer_mode_select
                        && CTRL_IN[scr_pkg::CTRL_BYTE_MODE_BIT]
                        && sel_ext_clk && op_ext_clk;
        // split clocking waits for the block clock to run
        ez_ready         = ENABLE_IN && SLAVE_MODE_IN && easy_buffer_mode
                        && !command_response_buffer_mode_select
                        && (op_ext_clk || BLOCK_CLOCK_GATE_IN);
    end

    // ****************************************************************
    // link domain: bit framing (cleared by every deselect)
    // ****************************************************************
    // deselect ends the frame, since sclk stops outside frames
    logic       link_rst_n;
    logic [2:0] l_bit_cnt_reg;
    logic [2:0] l_bit_cnt_next;
    logic       l_first_done_reg;
    logic       l_first_done_next;
    logic       l_phase_rd_reg;
    logic       l_phase_rd_next;
    logic [6:0] l_shift_reg;
    logic [6:0] l_shift_next;
    logic       l_byte_end;
    logic [7:0] l_byte;

    assign link_rst_n = RESET_N_IN && !SSEL_N_IN;

    // shift in mosi; first byte's last bit picks phase
    always_comb begin
        l_byte_end        = (l_bit_cnt_reg == scr_pkg::BIT_LAST);
        l_byte            = {l_shift_reg, MOSI_IN};
        l_bit_cnt_next    = l_bit_cnt_reg + 3'h1;
        l_shift_next      = l_byte[6:0];
        l_first_done_next = l_first_done_reg;
        l_phase_rd_next   = l_phase_rd_reg;
        if (l_byte_end && !l_first_done_reg) begin
            l_first_done_next = 1'b1;
            l_phase_rd_next   = l_byte[0];
        end
    end

    always_ff @(posedge SCLK_IN or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_bit_cnt_reg    <= scr_pkg::BIT_RESET;
            l_first_done_reg <= 1'b0;
            l_phase_rd_reg   <= 1'b0;
            l_shift_reg      <= 7'h00;
        end else begin
            l_bit_cnt_reg    <= l_bit_cnt_next;
            l_first_done_reg <= l_first_done_next;
            l_phase_rd_reg   <= l_phase_rd_next;
            l_shift_reg      <= l_shift_next;
        end
    end

    // ****************************************************************
    // link domain: config sync, toggles and held data
    // ****************************************************************
    // toggles survive deselect so no false edge reaches sys side
    // mode bits cross too, so the miso mux never reads a raw sys word
    logic [3:0] l_cfg_meta_reg;
    logic [3:0] l_cfg_sync_reg;
    logic       l_cr_sel;
    logic       l_ez_sel;
    logic       l_rx_tgl_reg;
    logic       l_rx_tgl_next;
    logic       l_cons_tgl_reg;
    logic       l_cons_tgl_next;
    logic [7:0] l_rx_data_reg;
    logic [7:0] l_rx_data_next;
    logic [7:0] l_tx_byte_reg;
    logic [7:0] l_tx_byte_next;
    logic       l_cr_ready;
    logic       l_ez_ready;
    logic       l_take_elem;
    logic [7:0] tx_hold_reg;
    logic       cr_ready_reg;

    // mosi is dropped unless the slave can use it
    always_comb begin
        l_cr_ready      = l_cfg_sync_reg[0];
        l_ez_ready      = l_cfg_sync_reg[1];
        l_cr_sel        = l_cfg_sync_reg[2];
        l_ez_sel        = l_cfg_sync_reg[3];
        l_take_elem     = l_byte_end && l_cr_ready
                       && (l_first_done_reg ? l_phase_rd_reg : l_byte[0]);
        l_rx_tgl_next   = l_rx_tgl_reg;
        l_rx_data_next  = l_rx_data_reg;
        l_cons_tgl_next = l_cons_tgl_reg;
        l_tx_byte_next  = l_tx_byte_reg;
        if (l_byte_end && l_cr_ready) begin
            l_rx_data_next = l_byte;
            l_rx_tgl_next  = !l_rx_tgl_reg;
        end
        if (l_take_elem) begin
            // sys holds tx_hold_reg still until this toggle is seen
            l_tx_byte_next  = tx_hold_reg;
            l_cons_tgl_next = !l_cons_tgl_reg;
        end
    end

    always_ff @(posedge SCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            l_cfg_meta_reg <= 4'h0;
            l_cfg_sync_reg <= 4'h0;
            l_rx_tgl_reg   <= 1'b0;
            l_cons_tgl_reg <= 1'b0;
            l_rx_data_reg  <= scr_pkg::BYTE_RESET;
            l_tx_byte_reg  <= scr_pkg::BYTE_RESET;
        end else begin
            l_cfg_meta_reg <= {easy_buffer_mode, command_response_buffer_mode_select,
                               ez_ready, cr_ready_reg};
            l_cfg_sync_reg <= l_cfg_meta_reg;
            l_rx_tgl_reg   <= l_rx_tgl_next;
            l_cons_tgl_reg <= l_cons_tgl_next;
            l_rx_data_reg  <= l_rx_data_next;
            l_tx_byte_reg  <= l_tx_byte_next;
        end
    end

    // ****************************************************************
    // link domain: miso selection
    // ****************************************************************
    logic [7:0] l_reply;
    logic [2:0] l_bit_idx;

    // first byte carries status; read phase carries elements
    always_comb begin
        l_bit_idx = scr_pkg::BIT_LAST - l_bit_cnt_reg;
        if (l_cr_sel) begin
            l_reply = l_cr_ready ? scr_pkg::REPLY_CR_READY
                                 : scr_pkg::REPLY_CR_BUSY;
        end else if (l_ez_sel) begin
            l_reply = l_ez_ready ? scr_pkg::REPLY_EZ_READY
                                 : scr_pkg::REPLY_EZ_BUSY;
        end else begin
            l_reply = scr_pkg::REPLY_IDLE;
        end
        if (!l_first_done_reg) begin
            MISO_OUT = l_reply[l_bit_idx];
        end else if (l_phase_rd_reg && l_cr_ready) begin
            MISO_OUT = l_tx_byte_reg[l_bit_idx];
        end else begin
            MISO_OUT = scr_pkg::REPLY_IDLE[l_bit_idx];
        end
        MISO_OE_OUT = !SSEL_N_IN;
    end

    // ****************************************************************
    // system domain: synchronisers
    // ****************************************************************
    logic ssel_meta_reg;
    logic ssel_sync_reg;
    logic ssel_prev_reg;
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic rx_prev_reg;
    logic cons_meta_reg;
    logic cons_sync_reg;
    logic cons_prev_reg;
    logic sel_start;
    logic sel_end;
    logic rx_evt;
    logic cons_evt;

    // second stage and its delayed copy feed the edge detectors
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ssel_meta_reg <= 1'b1;
            ssel_sync_reg <= 1'b1;
            ssel_prev_reg <= 1'b1;
            rx_meta_reg   <= 1'b0;
            rx_sync_reg   <= 1'b0;
            rx_prev_reg   <= 1'b0;
            cons_meta_reg <= 1'b0;
            cons_sync_reg <= 1'b0;
            cons_prev_reg <= 1'b0;
        end else begin
            ssel_meta_reg <= SSEL_N_IN;
            ssel_sync_reg <= ssel_meta_reg;
            ssel_prev_reg <= ssel_sync_reg;
            rx_meta_reg   <= l_rx_tgl_reg;
            rx_sync_reg   <= rx_meta_reg;
            rx_prev_reg   <= rx_sync_reg;
            cons_meta_reg <= l_cons_tgl_reg;
            cons_sync_reg <= cons_meta_reg;
            cons_prev_reg <= cons_sync_reg;
        end
    end

    assign sel_start = ssel_prev_reg && !ssel_sync_reg;
    assign sel_end   = !ssel_prev_reg && ssel_sync_reg;
    assign rx_evt    = rx_sync_reg ^ rx_prev_reg;
    assign cons_evt  = cons_sync_reg ^ cons_prev_reg;

    // ****************************************************************
    // system domain: frame control and addresses
    // ****************************************************************
    logic [7:0] mem_reg [0:DEPTH-1];
    scr_pkg::scr_frame_t frame_reg;
    scr_pkg::scr_frame_t frame_next;
    logic       phase_rd_reg;
    logic       phase_rd_next;
    logic       wrote_reg;
    logic       wrote_next;
    logic [7:0] cur_rd_reg;
    logic [7:0] cur_rd_next;
    logic [7:0] cur_wr_reg;
    logic [7:0] cur_wr_next;
    logic [7:0] tx_hold_next;
    logic       cr_ready_next;
    logic       wake_next;
    logic       xfer_end_next;
    logic       write_end_next;
    logic       link_we;

    always_comb begin
        frame_next     = frame_reg;
        phase_rd_next  = phase_rd_reg;
        wrote_next     = wrote_reg;
        cur_rd_next    = cur_rd_reg;
        cur_wr_next    = cur_wr_reg;
        tx_hold_next   = tx_hold_reg;
        link_we        = 1'b0;
        cr_ready_next  = command_response_buffer_mode_ok;
        wake_next      = sel_start && sel_ext_clk;
        xfer_end_next  = 1'b0;
        write_end_next = 1'b0;
        case (frame_reg)
            scr_pkg::SCR_FS_IDLE: begin
                if (sel_start) begin
                    frame_next   = scr_pkg::SCR_FS_CMD;
                    wrote_next   = 1'b0;
                    cur_wr_next  = BASE_WR_ADDR_IN;
                    cur_rd_next  = BASE_RD_ADDR_IN;
                    tx_hold_next = mem_reg[BASE_RD_ADDR_IN];
                end
            end
            scr_pkg::SCR_FS_CMD: begin
                if (rx_evt) begin
                    frame_next    = scr_pkg::SCR_FS_DATA;
                    phase_rd_next = l_rx_data_reg[0];
                end
            end
            scr_pkg::SCR_FS_DATA: begin
                if (rx_evt && !phase_rd_reg) begin
                    link_we     = 1'b1;
                    wrote_next  = 1'b1;
                    cur_wr_next = sat_inc(cur_wr_reg);
                end
            end
            default: begin
                frame_next = scr_pkg::SCR_FS_IDLE;
            end
        endcase
        // each element taken by the link advances the read pointer
        if (cons_evt && frame_reg != scr_pkg::SCR_FS_IDLE) begin
            cur_rd_next  = sat_inc(cur_rd_reg);
            tx_hold_next = mem_reg[sat_inc(cur_rd_reg)];
        end
        if (sel_end && frame_reg != scr_pkg::SCR_FS_IDLE) begin
            frame_next     = scr_pkg::SCR_FS_IDLE;
            xfer_end_next  = sel_ext_clk && op_ext_clk;
            write_end_next = sel_ext_clk && op_ext_clk && wrote_next;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            frame_reg     <= scr_pkg::SCR_FS_IDLE;
            phase_rd_reg  <= 1'b0;
            wrote_reg     <= 1'b0;
            cur_rd_reg    <= scr_pkg::ADDR_RESET;
            cur_wr_reg    <= scr_pkg::ADDR_RESET;
            tx_hold_reg   <= scr_pkg::BYTE_RESET;
            cr_ready_reg  <= 1'b0;
            WAKE_UP_OUT   <= 1'b0;
            XFER_END_OUT  <= 1'b0;
            WRITE_END_OUT <= 1'b0;
        end else begin
            frame_reg     <= frame_next;
            phase_rd_reg  <= phase_rd_next;
            wrote_reg     <= wrote_next;
            cur_rd_reg    <= cur_rd_next;
            cur_wr_reg    <= cur_wr_next;
            tx_hold_reg   <= tx_hold_next;
            cr_ready_reg  <= cr_ready_next;
            WAKE_UP_OUT   <= wake_next;
            XFER_END_OUT  <= xfer_end_next;
            WRITE_END_OUT <= write_end_next;
        end
    end

    // ****************************************************************
    // system domain: cpu window and buffer write port
    // ****************************************************************
    logic        cpu_grant;
    logic        ack_next;
    logic [31:0] rdata_next;
    logic        mem_we;
    logic [7:0]  mem_waddr;
    logic [7:0]  mem_wdata;

    // link writes win; a clashing cpu write simply waits a cycle
    always_comb begin
        cpu_grant  = CPU_REQ_IN && !CPU_ACK_OUT
                  && !(CPU_WE_IN && link_we);
        ack_next   = cpu_grant;
        rdata_next = CPU_RDATA_OUT;
        if (cpu_grant && !CPU_WE_IN) begin
            rdata_next = {24'h00_0000, mem_reg[CPU_ADDR_IN]};
        end
        mem_we    = link_we || (cpu_grant && CPU_WE_IN);
        mem_waddr = link_we ? cur_wr_reg : CPU_ADDR_IN;
        mem_wdata = link_we ? l_rx_data_reg : CPU_WDATA_IN[7:0];
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            CPU_ACK_OUT   <= 1'b0;
            CPU_RDATA_OUT <= 32'h0000_0000;
        end else begin
            CPU_ACK_OUT   <= ack_next;
            CPU_RDATA_OUT <= rdata_next;
        end
    end

    // buffer storage carries no reset
    always_ff @(posedge SYS_CLK_IN) begin
        if (mem_we) begin
            mem_reg[mem_waddr] <= mem_wdata;
        end
    end

    // ****************************************************************
    // status outputs
    // ****************************************************************
    // current addresses stay readable after deselect
    assign CUR_RD_ADDR_OUT     = cur_rd_reg;
    assign CUR_WR_ADDR_OUT     = cur_wr_reg;
    assign BUS_BUSY_OUT        = !ssel_sync_reg;
    assign COMMAND_RESPONSE_BUFFER_MODE_ACTIVE_OUT = cr_ready_reg;

endmodule : scr_spi_slave

// File: test/scr_spi_master.sv
/* behavioural spi master, mode 0, msb first, 64 ns link period.
 * assumes the bench calls its tasks one at a time. */
module scr_spi_master (
    // spi link
    output logic      sclk_out,
    output logic      ssel_n_out,
    output logic      mosi_out,
    input  wire logic miso_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // link drive
    // ****************************************************************
    // link clock stands low outside frames
    initial begin
        sclk_out = 1'b0;
        ssel_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // hold off so the system side sees the frame start in time
    task automatic sel();
        ssel_n_out = 1'b0;
        #700;
    endtask : sel
    // sample just before the rise, where miso is settled
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_out = tx[i];
            #32;
            rx[i] = miso_in;
            sclk_out = 1'b1;
            #32;
            sclk_out = 1'b0;
        end
    endtask : xbyte
    // released mosi shows the inverse, so stale data never matches
    task automatic desel();
        #32;
        ssel_n_out = 1'b1;
        mosi_out = ~mosi_out;
        #800;
    endtask : desel
endmodule : scr_spi_master

// File: test/scr_spi_slave_properties.sv
/* port-level checks for the command-response spi slave.
 * assumes it is bound onto every scr_spi_slave instance. */
module scr_spi_props (
    // clock and reset
    input wire logic        SYS_CLK_IN,
    input wire logic        RESET_N_IN,
    // watched ports
    input wire logic        SSEL_N_IN,
    input wire logic [31:0] CTRL_IN,
    input wire logic        SLAVE_MODE_IN,
    input wire logic        CPU_REQ_IN,
    input wire logic [31:0] CPU_RDATA_OUT,
    input wire logic        CPU_ACK_OUT,
    input wire logic        MISO_OE_OUT,
    input wire logic        COMMAND_RESPONSE_BUFFER_MODE_ACTIVE_OUT,
    input wire logic        WAKE_UP_OUT,
    input wire logic        XFER_END_OUT,
    input wire logic        WRITE_END_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // assertions, all on the system clock
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    a_ack_one_cycle: assert property (
        CPU_ACK_OUT |=> !CPU_ACK_OUT) else $error("ack too long");
    a_req_gets_ack: assert property (
        $rose(CPU_REQ_IN) |-> ##[1:2] CPU_ACK_OUT) else $error("no ack");
    a_rdata_low_byte: assert property (
        CPU_ACK_OUT |-> CPU_RDATA_OUT[31:8] == 24'h0) else $error("rdata");
    a_oe_follows_select: assert property (
        MISO_OE_OUT == !SSEL_N_IN) else $error("miso enable");
    a_wake_on_select: assert property (
        WAKE_UP_OUT |-> CTRL_IN[13] && !SSEL_N_IN) else $error("wake");
    a_end_on_deselect: assert property (
        XFER_END_OUT |-> CTRL_IN[13] && CTRL_IN[14] && SSEL_N_IN)
        else $error("transfer end");
    a_write_end_pair: assert property (
        WRITE_END_OUT |-> XFER_END_OUT) else $error("write end alone");
    a_command_response_buffer_mode_cfg: assert property (
        COMMAND_RESPONSE_BUFFER_MODE_ACTIVE_OUT |-> $past(CTRL_IN[12]) && $past(SLAVE_MODE_IN))
        else $error("command-response active without config");
endmodule : scr_spi_props

bind scr_spi_slave scr_spi_props u_props (.SYS_CLK_IN, .RESET_N_IN,
    .SSEL_N_IN, .CTRL_IN, .SLAVE_MODE_IN, .CPU_REQ_IN, .CPU_RDATA_OUT,
    .CPU_ACK_OUT, .MISO_OE_OUT, .COMMAND_RESPONSE_BUFFER_MODE_ACTIVE_OUT, .WAKE_UP_OUT,
    .XFER_END_OUT, .WRITE_END_OUT);

// File: test/scr_spi_slave_test.sv
/* self-checking bench for scr_spi_slave.
 * assumes the master model of scr_spi_master.sv on the link. */
module scr_spi_slave_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, sclk, ssel_n, mosi, miso, oe, ack, busy, cra;
    logic        wake, xend, wend, rst_n = 0, en = 1, slv = 1, gate = 0;
    logic        req = 0, we = 0;
    logic [1:0]  fmt = 2'h0;
    logic [31:0] ctrl = 0, wd = 0, rd, rdv;
    logic [7:0]  brd = 0, bwr = 0, addr = 0, crd, cwr, rep;
    logic [7:0]  tx [4];
    logic [7:0]  rx [4];
    int          mismatches, n_tests, wake_n, end_n, wend_n;
    // released line toggles so a stale bit never passes
    wire         miso_w = oe ? miso : ~sclk;

    scr_spi_slave u_dut (
        .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .SCLK_IN(sclk),
        .SSEL_N_IN(ssel_n), .MOSI_IN(mosi), .MISO_OUT(miso),
        .MISO_OE_OUT(oe), .CTRL_IN(ctrl), .ENABLE_IN(en),
        .SLAVE_MODE_IN(slv), .FRAME_FMT_IN(fmt),
        .BLOCK_CLOCK_GATE_IN(gate), .BASE_RD_ADDR_IN(brd),
        .BASE_WR_ADDR_IN(bwr), .CPU_REQ_IN(req), .CPU_WE_IN(we),
        .CPU_ADDR_IN(addr), .CPU_WDATA_IN(wd), .CPU_RDATA_OUT(rd),
        .CPU_ACK_OUT(ack), .CUR_RD_ADDR_OUT(crd),
        .CUR_WR_ADDR_OUT(cwr), .BUS_BUSY_OUT(busy),
        .COMMAND_RESPONSE_BUFFER_MODE_ACTIVE_OUT(cra), .WAKE_UP_OUT(wake),
        .XFER_END_OUT(xend), .WRITE_END_OUT(wend));
    scr_spi_master u_mst (.sclk_out(sclk), .ssel_n_out(ssel_n),
        .mosi_out(mosi), .miso_in(miso_w));

    // ****************************************************************
    // clock, event counters, shared tasks
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pulses last one cycle, so count them rather than poll
    always @(posedge clk) begin
        wake_n += (wake === 1'b1);
        end_n += (xend === 1'b1);
        wend_n += (wend === 1'b1);
    end
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // request held until ack is seen, then dropped
    task automatic cpu(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(negedge clk);
        {req, we, addr, wd} = {1'b1, w, a, d};
        for (int i = 0; i < 8 && ack !== 1'b1; i++) @(negedge clk);
        rdv = rd;
        chk({31'h0, ack}, 1);
        // keep the request up through the edge that sees ack high
        @(negedge clk);
        req = 1'b0;
    endtask : cpu
    // a first reply other than want makes the master retry the frame
    task automatic frame(input logic [7:0] cmd, want, input int n);
        for (int k = 0; k < 4; k++) begin
            u_mst.sel();
            chk({31'h0, busy}, 1);
            u_mst.xbyte(cmd, rep);
            for (int i = 0; i < n && rep === want; i++)
                u_mst.xbyte(tx[i], rx[i]);
            u_mst.desel();
            chk({31'h0, busy}, 0);
            if (rep === want) break;
        end
        @(negedge clk);
    endtask : frame
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_modes();
        chk({31'h0, cra}, 0);
        ctrl = 32'h1800;
        frame(8'h00, 8'h62, 0);
        chk({31'h0, rep !== 8'h62}, 1);
        {ctrl, en} = {32'h7800, 1'b0};
        frame(8'h00, 8'h62, 0);
        chk({24'h0, rep}, 32'hff);
        {en, slv} = 2'b10;
        repeat (4) @(negedge clk);
        chk({31'h0, cra}, 0);
        slv = 1'b1;
        repeat (4) @(negedge clk);
        chk({31'h0, cra}, 1);
        fmt = 2'h1;
        repeat (4) @(negedge clk);
        chk({31'h0, cra}, 0);
        fmt = 2'h0;
    endtask : t_modes
    task automatic t_cpu();
        cpu(1, 8'h03, 32'h1234_56a5);
        cpu(0, 8'h03, 0);
        chk(rdv, 32'ha5);
        cpu(1, 8'hff, 32'hffff_ff3c);
        cpu(0, 8'hff, 0);
        chk(rdv, 32'h3c);
    endtask : t_cpu
    // four bytes from 0xfd: the last two share the top location
    task automatic t_write();
        logic [7:0] ew [3];
        ew = '{8'h11, 8'h22, 8'h44};
        tx = '{8'h11, 8'h22, 8'h33, 8'h44};
        {bwr, wake_n, end_n, wend_n} = {8'hfd, 96'h0};
        frame(8'h00, 8'h62, 4);
        chk({24'h0, rep}, 32'h62);
        chk({24'h0, cwr}, 32'hff);
        chk(wend_n, 1);
        chk({30'h0, wake_n > 0, end_n > 0}, 3);
        for (int i = 0; i < 3; i++) begin
            cpu(0, 8'(8'hfd + i), 0);
            chk(rdv, {24'h0, ew[i]});
        end
    endtask : t_write
    task automatic t_read();
        {brd, wend_n} = {8'hfd, 32'h0};
        frame(8'h01, 8'h62, 4);
        chk({rx[0], rx[1], rx[2], rx[3]}, 32'h1122_4444);
        chk({24'h0, crd}, 32'hff);
        chk(wend_n, 0);
    endtask : t_read
    task automatic t_easy();
        ctrl = 32'h2c00;
        frame(8'h00, 8'hff, 0);
        chk({24'h0, rep}, 32'hff);
        gate = 1'b1;
        frame(8'h00, 8'hfe, 0);
        chk({24'h0, rep}, 32'hfe);
    endtask : t_easy

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        t_modes();
        t_cpu();
        t_write();
        t_read();
        t_easy();
        test_done();
    end
    // at most 24 frames, retries included, fit well inside this
    initial begin
        #1_000_000;
        mismatches++;
        test_done();
    end
endmodule : scr_spi_slave_test
